// [hw/doc_pkg.sv]
// package: register map, field layout, modes and timing constants of the output conditioner
package doc_pkg;
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 4;
  // register byte offsets (word aligned)
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CHCFG = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_IRQ = 4'hc;
  // ctrl fields
  localparam int CTRL_ACTIVE = 0;
  localparam int CTRL_TMO_SHIFT = 8;
  localparam int CTRL_TMO_W = 16;
  // per-channel config fields, 8 bits per channel
  localparam int CFG_STRIDE = 8;
  localparam int CFG_SIM = 0;
  localparam int CFG_SIM_VAL = 1;
  localparam int CFG_SIM_INV = 2;
  localparam int CFG_EMODE = 3;
  localparam int CFG_SUBST = 5;
  localparam int CFG_INVERT = 6;
  localparam int CFG_LFD_EN = 7;
  // status fields, 4 bits per channel group
  localparam int ST_OUT = 0;
  localparam int ST_LF = 4;
  localparam int ST_ERR = 8;
  localparam int ST_WD = 12;
  // interrupt events
  localparam int IRQ_W = 6;
  localparam int IRQ_WD = 4;
  localparam int IRQ_MISS = 5;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CHCFG_RST = 32'h0000_0000;
  // error modes
  typedef enum logic [1:0] {
    DOC_EM_CURRENT = 2'b00,
    DOC_EM_SUBST = 2'b01,
    DOC_EM_LAST = 2'b10
  } doc_emode_t;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int WD_TIME_MS = 500;
  localparam int WD_FAIL_LIMIT = 3;
  localparam logic [1:0] WD_FAIL_MAX = 2'h3;
  localparam int MS_CNT_W = 15;
  localparam int DLY_W = 8;
endpackage

// [hw/doc_ms_tick.sv]
// module: millisecond enable pulse divider
`timescale 1ns/100ps
`default_nettype none
module doc_ms_tick (
  input wire logic core_clk, // module clock
  input wire logic rstn, // synchronous reset, low active
  output logic tick // one-cycle pulse every millisecond
);
  logic [doc_pkg::MS_CNT_W-1:0] cnt_reg;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else if (cnt_reg == doc_pkg::MS_CNT_W'(doc_pkg::MS_CYC - 1)) begin
      cnt_reg <= '0;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [hw/doc_delay.sv]
// module: on/off delay stage for one output channel
`timescale 1ns/100ps
`default_nettype none
module doc_delay (
  input wire logic core_clk, // module clock
  input wire logic rstn, // synchronous reset, low active
  input wire logic ms_tick, // millisecond enable
  input wire logic din, // requested level
  input wire logic [doc_pkg::DLY_W-1:0] on_ms, // 0 to 1 delay in ms
  input wire logic [doc_pkg::DLY_W-1:0] off_ms, // 1 to 0 delay in ms
  output logic dout // delayed level
);
  logic [doc_pkg::DLY_W-1:0] cnt_reg;
  logic [doc_pkg::DLY_W-1:0] lim;

  always_comb begin
    lim = din ? on_ms : off_ms;
  end

  // a change is passed once it has stood for the set number of ms
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_reg <= '0;
      dout <= 1'b0;
    end else if (din == dout) begin
      cnt_reg <= '0;
    end else if (cnt_reg >= lim) begin
      dout <= din; // R15 R16
      cnt_reg <= '0;
    end else if (ms_tick) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire

// [hw/doc_conditioner.sv]
// module: digital output channel conditioner with avalon-mm registers
//
// Overview of operation
// R1 - normal mode: output follows the latest bus value of the channel.
// R2 - simulation mode: bus value ignored, configured simulation value is output.
// R3 - watchdog expiry starts error handling with the configured error mode; the code sets the error flags but forces all outputs to 0.
// R4 - a value received with invalid status also starts error handling.
// R5 - in error, output replaced by one of three per-channel strategies.
// R6 - line faults never start substitution; output keeps its normal source.
// R7 - current-value mode passes the incoming or simulated signal unchanged.
// R8 - substitute mode drives the per-channel substitute bit during error.
// R9 - last-valid mode drives the final value valid before the fault.
// R10 - inversion enabled complements the output level.
// R11 - with monitoring on, open lead or short is reported in channel status.
// R12 - channels follow the module active setting, no own activation.
// R13 - three failed com attempts then 500 ms switch outputs off.
// R14 - com unit sends value bit then validity bit; 1 means invalid.
// R15 - configurable ms delay stretches 1 to 0 transitions.
// R16 - configurable ms delay filters 0 to 1 transitions.
// R17 - last-valid register loads on each valid receipt, frozen during error; the code still loads it in simulation mode with the simulated invalid bit set.
// R18 - inversion after selection, before on and off delays.
`timescale 1ns/100ps
`default_nettype none
module doc_conditioner (
  input wire logic core_clk, // module clock, 20 MHz
  input wire logic rstn, // synchronous reset, low active
  input wire logic [3:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic [3:0] bus_value, // per-channel value from com unit
  input wire logic [3:0] bus_invalid, // per-channel validity, 1 = invalid
  input wire logic bus_strobe, // one-cycle pulse: new frame received
  input wire logic com_fail, // one-cycle pulse: failed com attempt
  input wire logic [3:0] line_fault_pin, // raw line-fault detector, async
  output logic [3:0] out_drive, // channel output drive
  output logic irq // interrupt, high level
);
  localparam int N = doc_pkg::NUM_CH;
  localparam int WD_CYC = doc_pkg::WD_TIME_MS * doc_pkg::MS_CYC;
  localparam int WD_CNT_W = 24; // holds the 500 ms count at 20 MHz
  localparam int MASK_POS = 16; // mask field position in the interrupt word
  localparam int DLY_POS = 16; // delay copy position in the status word

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] ctrl_reg;
  logic [31:0] chcfg_reg;
  logic [31:0] dly_reg;
  logic [doc_pkg::IRQ_W-1:0] irq_st_reg;
  logic [doc_pkg::IRQ_W-1:0] irq_mask_reg;
  logic ack_reg;
  logic [N-1:0] val_reg;
  logic [N-1:0] inv_reg;
  logic [N-1:0] last_reg;
  logic [N-1:0] lf_reg;
  logic [1:0] fail_cnt_reg;
  logic wd_arm_reg;
  logic wd_off_reg;
  logic [WD_CNT_W-1:0] wd_cnt_reg;
  logic [N-1:0] lf_s1_reg;
  logic [N-1:0] lf_s2_reg;
  logic [N-1:0] lf_s3_reg;
  logic [N-1:0] sel;
  logic [N-1:0] err;
  logic [N-1:0] delayed;
  logic ms_tick;
  logic active;

  // byte-lane merge of a write
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // register select decode
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    return a == ofs;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // avalon-mm slave: one wait cycle, answer on the second edge
  wire req = (avs_read | avs_write) & !ack_reg;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !req;
    end
  end

  // a write lands at the edge where waitrequest is seen low
  wire wr_go = avs_write & ack_reg;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctrl_reg <= doc_pkg::CTRL_RST;
      chcfg_reg <= doc_pkg::CHCFG_RST;
      irq_mask_reg <= '0;
    end else if (wr_go) begin
      if (hit(avs_address, doc_pkg::OFS_CTRL)) begin
        ctrl_reg <= be_merge(ctrl_reg, avs_writedata, avs_byteenable);
      end
      if (hit(avs_address, doc_pkg::OFS_CHCFG)) begin
        chcfg_reg <= be_merge(chcfg_reg, avs_writedata, avs_byteenable);
      end
      if (hit(avs_address, doc_pkg::OFS_IRQ) && avs_byteenable[2]) begin
        irq_mask_reg <= avs_writedata[MASK_POS +: doc_pkg::IRQ_W];
      end
    end
  end

  // delay settings share the status offset on write: on ms low byte, off ms next byte
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dly_reg <= '0;
    end else if (wr_go && hit(avs_address, doc_pkg::OFS_STAT)) begin
      dly_reg <= be_merge(dly_reg, avs_writedata, avs_byteenable);
    end
  end

  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[doc_pkg::ST_OUT +: N] = out_drive;
    status_word[doc_pkg::ST_LF +: N] = lf_reg;
    status_word[doc_pkg::ST_ERR +: N] = err;
    status_word[doc_pkg::ST_WD] = wd_off_reg;
    status_word[DLY_POS +: 2 * doc_pkg::DLY_W] = dly_reg[2 * doc_pkg::DLY_W - 1:0];
  end

  logic [31:0] irq_word;
  always_comb begin
    irq_word = '0;
    irq_word[0 +: doc_pkg::IRQ_W] = irq_st_reg;
    irq_word[MASK_POS +: doc_pkg::IRQ_W] = irq_mask_reg;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      avs_readdata <= '0;
    end else if (avs_read & req) begin
      unique case (avs_address)
        doc_pkg::OFS_CTRL: avs_readdata <= ctrl_reg;
        doc_pkg::OFS_CHCFG: avs_readdata <= chcfg_reg;
        doc_pkg::OFS_STAT: avs_readdata <= status_word;
        doc_pkg::OFS_IRQ: avs_readdata <= irq_word;
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus frame capture and last-valid hold
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      val_reg <= '0;
      inv_reg <= '1;
    end else if (bus_strobe) begin
      val_reg <= bus_value; // R1 R14
      inv_reg <= bus_invalid; // R4 R14
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      last_reg <= '0;
    end else if (bus_strobe) begin
      for (int c = 0; c < N; c++) begin
        if (!bus_invalid[c] && !wd_off_reg) begin
          last_reg[c] <= bus_value[c]; // R17
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: three failed attempts arm it, 500 ms later outputs go off
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fail_cnt_reg <= '0;
      wd_arm_reg <= 1'b0;
    end else if (bus_strobe) begin
      fail_cnt_reg <= '0;
      wd_arm_reg <= 1'b0;
    end else if (com_fail) begin
      if (fail_cnt_reg == doc_pkg::WD_FAIL_MAX - 2'h1) begin
        wd_arm_reg <= 1'b1; // R13
      end
      if (fail_cnt_reg != doc_pkg::WD_FAIL_MAX) begin
        fail_cnt_reg <= fail_cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wd_cnt_reg <= '0;
      wd_off_reg <= 1'b0;
    end else if (!wd_arm_reg) begin
      wd_cnt_reg <= '0;
      wd_off_reg <= 1'b0;
    end else if (wd_cnt_reg == WD_CNT_W'(WD_CYC - 1)) begin
      wd_off_reg <= 1'b1; // R3 R13
    end else begin
      wd_cnt_reg <= wd_cnt_reg + WD_CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // line fault synchroniser: change accepted when stages two and three agree
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      lf_s1_reg <= '0;
      lf_s2_reg <= '0;
      lf_s3_reg <= '0;
      lf_reg <= '0;
    end else begin
      lf_s1_reg <= line_fault_pin;
      lf_s2_reg <= lf_s1_reg;
      lf_s3_reg <= lf_s2_reg;
      for (int c = 0; c < N; c++) begin
        if (lf_s2_reg[c] == lf_s3_reg[c]) begin
          lf_reg[c] <= lf_s3_reg[c] & chcfg_reg[c*doc_pkg::CFG_STRIDE + doc_pkg::CFG_LFD_EN]; // R11
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // per-channel source and error-mode selection
  assign active = ctrl_reg[doc_pkg::CTRL_ACTIVE]; // R12

  doc_ms_tick u_tick (
    .core_clk(core_clk),
    .rstn(rstn),
    .tick(ms_tick)
  );

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      wire [doc_pkg::CFG_STRIDE-1:0] cfg = chcfg_reg[g*doc_pkg::CFG_STRIDE +: doc_pkg::CFG_STRIDE];
      wire sim = cfg[doc_pkg::CFG_SIM];
      wire src = sim ? cfg[doc_pkg::CFG_SIM_VAL] : val_reg[g]; // R1 R2
      wire src_bad = sim ? cfg[doc_pkg::CFG_SIM_INV] : inv_reg[g];
      doc_pkg::doc_emode_t em;
      logic pick;
      // line fault is deliberately not part of the error term
      assign err[g] = wd_off_reg | src_bad; // R3 R4 R6
      assign em = doc_pkg::doc_emode_t'(cfg[doc_pkg::CFG_EMODE +: 2]);
      always_comb begin
        pick = src;
        if (err[g]) begin
          unique case (em) // R5
            doc_pkg::DOC_EM_CURRENT: pick = src; // R7
            doc_pkg::DOC_EM_SUBST: pick = cfg[doc_pkg::CFG_SUBST]; // R8
            doc_pkg::DOC_EM_LAST: pick = last_reg[g]; // R9
            default: pick = src;
          endcase
        end
      end
      assign sel[g] = active & (pick ^ cfg[doc_pkg::CFG_INVERT]); // R10 R12 R18

      doc_delay u_dly (
        .core_clk(core_clk),
        .rstn(rstn),
        .ms_tick(ms_tick),
        .din(sel[g]), // R18
        .on_ms(dly_reg[doc_pkg::DLY_W-1:0]),
        .off_ms(dly_reg[doc_pkg::DLY_W +: doc_pkg::DLY_W]),
        .dout(delayed[g])
      );
    end
  endgenerate

  // watchdog shutdown and module inactive override the delay stage at once
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      out_drive <= '0;
    end else begin
      out_drive <= (wd_off_reg | !active) ? '0 : delayed; // R12 R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts: line-fault rise per channel, watchdog off, missed frame
  logic [N-1:0] lf_prev_reg;
  logic wd_prev_reg;
  logic [doc_pkg::IRQ_W-1:0] ev;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      lf_prev_reg <= '0;
      wd_prev_reg <= 1'b0;
    end else begin
      lf_prev_reg <= lf_reg;
      wd_prev_reg <= wd_off_reg;
    end
  end

  always_comb begin
    ev = '0;
    ev[N-1:0] = lf_reg & ~lf_prev_reg;
    ev[doc_pkg::IRQ_WD] = wd_off_reg & ~wd_prev_reg;
    ev[doc_pkg::IRQ_MISS] = com_fail;
  end

  // set wins over a same-cycle write-one clear
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      irq_st_reg <= '0;
    end else if (wr_go && hit(avs_address, doc_pkg::OFS_IRQ) && avs_byteenable[0]) begin
      irq_st_reg <= (irq_st_reg & ~avs_writedata[doc_pkg::IRQ_W-1:0]) | ev;
    end else begin
      irq_st_reg <= irq_st_reg | ev;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_st_reg & irq_mask_reg);
    end
  end
endmodule
`default_nettype wire

// [dv/doc_com_model.sv]
// partner: com unit model sending channel frames and failed attempts
`timescale 1ns/100ps
`default_nettype none
module doc_com_model (
  input wire logic core_clk, // module clock
  output logic [3:0] bus_value, // channel values
  output logic [3:0] bus_invalid, // 1 marks a channel invalid
  output logic bus_strobe, // frame pulse
  output logic com_fail // failed attempt pulse
);
  initial begin
    bus_value = 4'h0;
    bus_invalid = 4'hf;
    bus_strobe = 1'h0;
    com_fail = 1'h0;
  end
  // lines outside a frame carry the inverse of the last frame
  task automatic send(input logic [3:0] v, input logic [3:0] i);
    bus_value <= v;
    bus_invalid <= i;
    bus_strobe <= 1'h1;
    @(posedge core_clk);
    bus_strobe <= 1'h0;
    bus_value <= ~v;
    bus_invalid <= ~i;
  endtask
  task automatic fail;
    com_fail <= 1'h1;
    @(posedge core_clk);
    com_fail <= 1'h0;
  endtask
endmodule
`default_nettype wire

// [dv/doc_conditioner_chk.sv]
// checker: bus handshake, reset, activation and interrupt assertions
`timescale 1ns/100ps
`default_nettype none
module doc_conditioner_chk (
  input wire logic core_clk, // clock
  input wire logic rstn, // reset, low active
  input wire logic [3:0] avs_address, // address
  input wire logic avs_read, // read
  input wire logic avs_write, // write
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // lanes
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // stall
  input wire logic [3:0] bus_value, // values
  input wire logic [3:0] bus_invalid, // validity
  input wire logic bus_strobe, // frame
  input wire logic com_fail, // failed attempt
  input wire logic [3:0] line_fault_pin, // line faults
  input wire logic [3:0] out_drive, // outputs
  input wire logic irq // interrupt
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////
  logic act_reg;
  logic [5:0] mask_reg;
  wire logic acc = avs_write && !avs_waitrequest;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      act_reg <= 1'h0;
    end else if (acc && avs_address == doc_pkg::OFS_CTRL && avs_byteenable[0]) begin
      act_reg <= avs_writedata[doc_pkg::CTRL_ACTIVE];
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mask_reg <= 6'h00;
    end else if (acc && avs_address == doc_pkg::OFS_IRQ && avs_byteenable[2]) begin
      mask_reg <= avs_writedata[21:16];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_req;
    (avs_read || avs_write);
  endsequence
  sequence s_ans;
    ##[0:2] !avs_waitrequest;
  endsequence
  chk_answer_bound: assert property (s_req |-> s_ans)
    else $error("request not answered in time");
  chk_wait_pulse: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
    |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_readdata_hold: assert property ($changed(avs_readdata) |-> $past(avs_read))
    else $error("read data moved without read");
  chk_inactive_off: assert property (!act_reg [*3] |-> out_drive == 4'h0)
    else $error("output driven while module inactive");
  chk_irq_masked: assert property (irq |-> (mask_reg | $past(mask_reg) | $past(mask_reg, 2)) != 6'h00)
    else $error("interrupt with all events masked");
  chk_reset_clear: assert property (disable iff (1'h0) !rstn |=> out_drive == 4'h0 && !irq
    && avs_waitrequest)
    else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// [dv/doc_conditioner_tb.sv]
// testbench: conditioner against a behavioural channel model
`timescale 1ns/100ps
`default_nettype none
module doc_conditioner_tb;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'h0;
  logic [3:0] line_fault_pin = 4'h0;
  logic [31:0] avs_readdata, q;
  logic [3:0] bus_value, bus_invalid, out_drive;
  logic avs_waitrequest, bus_strobe, com_fail, irq;
  logic [7:0] cfg [4];
  logic [3:0] last_q = 4'h0;
  int err_total = 0;
  int comparisons = 0;
  doc_conditioner u_dut (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bus_value(bus_value), .bus_invalid(bus_invalid),
    .bus_strobe(bus_strobe), .com_fail(com_fail), .line_fault_pin(line_fault_pin),
    .out_drive(out_drive), .irq(irq));
  doc_com_model u_com (.core_clk(core_clk), .bus_value(bus_value), .bus_invalid(bus_invalid),
    .bus_strobe(bus_strobe), .com_fail(com_fail));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] be);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'h0) @(posedge core_clk);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic settle(input logic [3:0] x);
    for (int n = 0; n < 40000 && out_drive !== x; n++) @(posedge core_clk);
    check(out_drive, x);
  endtask
  // returns {error, output level} of one channel
  function automatic logic [1:0] model_ch(input logic [7:0] k, input logic v, input logic i,
    input logic l);
    logic src;
    logic err;
    logic sel;
    src = k[0] ? k[1] : v;
    err = k[0] ? k[2] : i;
    sel = !err ? src : k[4:3] == 2'h1 ? k[5] : k[4:3] == 2'h2 ? l : src;
    return {err, sel ^ k[6]};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #(100000 * 50);
    err_total++;
    results();
  end
  initial begin
    logic [3:0] v, i, e, o;
    logic [1:0] r;
    void'($urandom(32'h0000_04a3));
    repeat (5) @(posedge core_clk);
    rstn <= 1'h1;
    @(posedge core_clk);
    bus(1'h0, doc_pkg::OFS_CTRL, 32'h0000_0000, 4'hf);
    check(q, doc_pkg::CTRL_RST);
    bus(1'h0, doc_pkg::OFS_CHCFG, 32'h0000_0000, 4'hf);
    check(q, doc_pkg::CHCFG_RST);
    bus(1'h1, 4'h2, 32'hffff_ffff, 4'hf);
    bus(1'h0, 4'h2, 32'h0000_0000, 4'hf);
    check(q, 32'h0000_0000);
    u_com.send(4'hf, 4'h0);
    last_q = 4'hf;
    repeat (4) @(posedge core_clk);
    check(out_drive, 4'h0);
    bus(1'h1, doc_pkg::OFS_CTRL, 32'h0000_0001, 4'h1);
    for (int n = 0; n < 16; n++) begin
      for (int c = 0; c < 4; c++) begin
        cfg[c] = 8'($urandom) & 8'h7f;
        if (cfg[c][0] && cfg[c][4:3] == 2'h2) cfg[c][4:3] = 2'h0;
      end
      bus(1'h1, doc_pkg::OFS_CHCFG, {cfg[3], cfg[2], cfg[1], cfg[0]}, 4'hf);
      v = 4'($urandom);
      i = 4'($urandom) & 4'($urandom);
      u_com.send(v, i);
      for (int c = 0; c < 4; c++) begin
        r = model_ch(cfg[c], v[c], i[c], last_q[c]);
        {e[c], o[c]} = r;
        if (!i[c]) last_q[c] = v[c];
      end
      repeat (4) @(posedge core_clk);
      check(out_drive, o);
      bus(1'h0, doc_pkg::OFS_STAT, 32'h0000_0000, 4'hf);
      check(q[12:0], {1'h0, e, 4'h0, o});
    end
    bus(1'h1, doc_pkg::OFS_CHCFG, 32'h0000_0080, 4'hf);
    u_com.send(4'h1, 4'h0);
    line_fault_pin <= 4'h1;
    repeat (8) @(posedge core_clk);
    check(out_drive, 4'h1);
    bus(1'h0, doc_pkg::OFS_STAT, 32'h0000_0000, 4'hf);
    check(q[11:4], 8'h01);
    bus(1'h1, doc_pkg::OFS_IRQ, 32'h0021_0000, 4'h4);
    repeat (3) @(posedge core_clk);
    check(irq, 1'h1);
    bus(1'h1, doc_pkg::OFS_IRQ, 32'h0000_0001, 4'h1);
    repeat (3) @(posedge core_clk);
    check(irq, 1'h0);
    u_com.fail();
    repeat (3) @(posedge core_clk);
    check(irq, 1'h1);
    u_com.fail();
    @(posedge core_clk);
    u_com.fail();
    repeat (200) @(posedge core_clk);
    bus(1'h0, doc_pkg::OFS_STAT, 32'h0000_0000, 4'hf);
    check(q[12:0], 13'h0011);
    bus(1'h0, doc_pkg::OFS_IRQ, 32'h0000_0000, 4'hf);
    check(q[5:0], 6'h20);
    bus(1'h1, doc_pkg::OFS_IRQ, 32'h0000_0020, 4'h1);
    repeat (3) @(posedge core_clk);
    check(irq, 1'h0);
    line_fault_pin <= 4'h0;
    u_com.send(4'h0, 4'h0);
    bus(1'h1, doc_pkg::OFS_STAT, 32'h0000_0202, 4'h3);
    bus(1'h0, doc_pkg::OFS_STAT, 32'h0000_0000, 4'hf);
    check(q[31:16], 16'h0202);
    u_com.send(4'hf, 4'h0);
    repeat (10000) @(posedge core_clk);
    check(out_drive, 4'h0);
    settle(4'hf);
    u_com.send(4'h0, 4'h0);
    repeat (10000) @(posedge core_clk);
    check(out_drive, 4'hf);
    settle(4'h0);
    rstn <= 1'h0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'h1;
    @(posedge core_clk);
    bus(1'h0, doc_pkg::OFS_CTRL, 32'h0000_0000, 4'hf);
    check(q, doc_pkg::CTRL_RST);
    bus(1'h0, doc_pkg::OFS_STAT, 32'h0000_0000, 4'hf);
    check({q[31:12], q[7:0]}, 28'h000_0000);
    bus(1'h1, doc_pkg::OFS_CTRL, 32'h0000_0000, 4'h1);
    results();
  end
endmodule
bind doc_conditioner doc_conditioner_chk u_chk (.core_clk(core_clk), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus_value(bus_value),
  .bus_invalid(bus_invalid), .bus_strobe(bus_strobe), .com_fail(com_fail),
  .line_fault_pin(line_fault_pin), .out_drive(out_drive), .irq(irq));
`default_nettype wire
